// ==== txpo_pkg.sv ====
// Register map, field layout, reset values and carrier types of the block
package txpo_pkg;

  localparam int APB_AW = 12;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_PTR_CTRL    = 8'h41;
  localparam logic [7:0] IDX_SRC_SEL     = 8'h42;
  localparam logic [7:0] IDX_ARB_LOW     = 8'h45;
  localparam logic [7:0] IDX_ARB_HIGH    = 8'h46;
  localparam logic [7:0] IDX_LABEL       = 8'h48;
  localparam logic [7:0] IDX_PATH_STATUS = 8'h49;

  // Pointer control fields
  localparam int PC_POS_BIT  = 1;
  localparam int PC_NEG_BIT  = 2;
  localparam int PC_FLAG_BIT = 3;
  localparam int PC_LOAD_BIT = 4;
  localparam int PC_GAP_BIT  = 5;

  // Pointer high / flags fields
  localparam int AH_PTR_LSB  = 0;
  localparam int AH_SPARE_LSB = 2;
  localparam int AH_FLAG_LSB = 4;

  // Path status fields
  localparam int PS_SPARE_LSB = 0;
  localparam int PS_YEL_BIT   = 3;
  localparam int PS_ERR_LSB   = 4;

  // Reset values
  localparam logic [7:0] RST_PTR_CTRL    = 8'h00;
  localparam logic [7:0] RST_SRC_SEL     = 8'h00;
  localparam logic [7:0] RST_ARB_LOW     = 8'h00;
  localparam logic [7:0] RST_ARB_HIGH    = 8'h90;
  localparam logic [7:0] RST_LABEL       = 8'h13;
  localparam logic [7:0] RST_PATH_STATUS = 8'h00;

  // Pointer and error count constants
  localparam logic [9:0] PTR_MAX       = 10'h30e;
  localparam logic [9:0] PTR_INC_MASK  = 10'h2aa;
  localparam logic [9:0] PTR_DEC_MASK  = 10'h155;
  localparam logic [3:0] FLAG_NORMAL   = 4'h6;
  localparam logic [1:0] STUFF_GAP     = 2'h3;
  localparam logic [3:0] ERR_CNT_MAX   = 4'h8;

  // Path overhead byte slots offered by the frame timing
  typedef enum logic [2:0] {
    SLOT_J1, SLOT_F2, SLOT_G1, SLOT_C2, SLOT_Z3, SLOT_Z4, SLOT_Z5, SLOT_NONE
  } txpo_slot_t;

  typedef struct packed {
    txpo_slot_t slot;
    logic [7:0] data;
  } txpo_poh_t;

  typedef struct packed {
    logic [15:0] word;
    logic        pos_stuff;
    logic        neg_stuff;
    logic [9:0]  timing_ptr;
  } txpo_ptr_t;

endpackage

// ==== txpo_tx_path_overhead_proc.sv ====
// Transmit path overhead insertion and payload pointer generation
`timescale 1ns/100ps
// What this block does
// - Stuff spacing select limits one stuff per four frames
// - Per-byte source select ORed with external enable
// - Selected bytes come from serial input slot
// - Otherwise insert the byte's internal default
// - Ten-bit arbitrary pointer from low and high
// - Writing load bit inserts the arbitrary pointer
// - Spare bits fill every transmitted pointer
// - Programmed flag pattern on load or continuous
// - Signal label register fills C2 byte
// - Remote error register fills G1 error bits
// - Remote error field clears after insertion
// - Non-zero override replaces accumulated error count
// - Remote error field reads its current value
// - Yellow bit is register OR yellow input
// - External source overrides register yellow bit
// - Status spare bits fill unused G1 bits
// - Rising request bit gives one justification
// - Without continuous flags insert normal pattern
// - Loaded flag only first frame; load clears
// - Out-of-range load sent; timing keeps last
module txpo_tx_path_overhead_proc #(
  parameter logic [7:0] DEF_TRACE  = 8'h00,
  parameter logic [7:0] DEF_USER   = 8'h00,
  parameter logic [7:0] DEF_GROWTH = 8'h00
) (
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [txpo_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       frame_start,
  input  wire txpo_pkg::txpo_slot_t       poh_slot,
  input  wire logic                       poh_bit_strobe,
  input  wire logic [2:0]                 poh_bit_idx,
  input  wire logic                       ext_overhead_enable,
  input  wire logic                       ext_overhead_serial_in,
  input  wire logic                       remote_error_pulse_in,
  input  wire logic                       path_yellow_in,
  output txpo_pkg::txpo_poh_t             poh_out,
  output logic                            poh_out_valid,
  output txpo_pkg::txpo_ptr_t             ptr_out,
  output logic                            ptr_out_valid
);
  import txpo_pkg::*;

  logic [7:0] ptr_ctrl_q;
  logic [7:0] src_sel_q;
  logic [7:0] arb_low_q;
  logic [7:0] arb_high_q;
  logic [7:0] label_q;
  logic [7:0] status_q;
  logic [31:0] prdata_q;

  logic       setup;
  logic       wr_acc;
  logic       mapped;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;

  function automatic logic hit(input logic [APB_AW-1:0] a,
                               input logic [7:0] idx);
    hit = (a == {{(APB_AW-10){1'b0}}, idx, 2'b00});
  endfunction

  function automatic logic [9:0] ptr_step(input logic [9:0] p,
                                          input logic up);
    if (up) begin
      ptr_step = (p >= PTR_MAX) ? 10'h000 : p + 10'h001;
    end else begin
      ptr_step = (p == 10'h000) ? PTR_MAX : p - 10'h001;
    end
  endfunction

  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pwrite;
  assign wr_byte = pwdata[7:0];
  assign mapped  = hit(paddr, IDX_PTR_CTRL) | hit(paddr, IDX_SRC_SEL) |
                   hit(paddr, IDX_ARB_LOW) | hit(paddr, IDX_ARB_HIGH) |
                   hit(paddr, IDX_LABEL) | hit(paddr, IDX_PATH_STATUS);

  // Zero wait states; read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;

  always_comb begin
    rd_byte = 8'h00;
    if (hit(paddr, IDX_PTR_CTRL)) begin
      rd_byte = ptr_ctrl_q;
    end else if (hit(paddr, IDX_SRC_SEL)) begin
      rd_byte = src_sel_q;
    end else if (hit(paddr, IDX_ARB_LOW)) begin
      rd_byte = arb_low_q;
    end else if (hit(paddr, IDX_ARB_HIGH)) begin
      rd_byte = arb_high_q;
    end else if (hit(paddr, IDX_LABEL)) begin
      rd_byte = label_q;
    end else if (hit(paddr, IDX_PATH_STATUS)) begin
      rd_byte = status_q;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // Plain configuration registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      src_sel_q  <= RST_SRC_SEL;
      arb_low_q  <= RST_ARB_LOW;
      arb_high_q <= RST_ARB_HIGH;
      label_q    <= RST_LABEL;
    end else if (wr_acc) begin
      if (hit(paddr, IDX_SRC_SEL)) begin
        src_sel_q <= {1'b0, wr_byte[6:0]};
      end
      if (hit(paddr, IDX_ARB_LOW)) begin
        arb_low_q <= wr_byte;
      end
      if (hit(paddr, IDX_ARB_HIGH)) begin
        arb_high_q <= wr_byte;
      end
      if (hit(paddr, IDX_LABEL)) begin
        label_q <= wr_byte;
      end
    end
  end

  // Pointer generation
  logic [9:0] arb_ptr;
  logic [1:0] spare_bits;
  logic [3:0] new_flag_pattern;
  logic [3:0] flag_sel;
  logic       stuff_spacing_sel;
  logic       pos_justify_req;
  logic       neg_justify_req;
  logic       pointer_load;
  logic       flag_insert_enable;
  logic       space_ok;
  logic       do_load;
  logic       do_pos;
  logic       do_neg;
  logic [9:0] tx_ptr_q;
  logic [9:0] timing_ptr_q;
  logic [1:0] gap_cnt_q;
  txpo_ptr_t  ptr_q;
  logic       ptr_valid_q;

  assign arb_ptr = {arb_high_q[AH_PTR_LSB +: 2], arb_low_q};
  assign spare_bits         = arb_high_q[AH_SPARE_LSB +: 2];
  assign new_flag_pattern   = arb_high_q[AH_FLAG_LSB +: 4];
  assign stuff_spacing_sel  = ptr_ctrl_q[PC_GAP_BIT];
  assign pos_justify_req    = ptr_ctrl_q[PC_POS_BIT];
  assign neg_justify_req    = ptr_ctrl_q[PC_NEG_BIT];
  assign pointer_load       = ptr_ctrl_q[PC_LOAD_BIT];
  assign flag_insert_enable = ptr_ctrl_q[PC_FLAG_BIT];

  // Continuous flags, else the normal pattern
  assign flag_sel = flag_insert_enable ? new_flag_pattern
                                       : FLAG_NORMAL;
  assign space_ok = !stuff_spacing_sel || (gap_cnt_q == STUFF_GAP);
  assign do_load  = frame_start && pointer_load;
  assign do_pos   = frame_start && !pointer_load &&
                    pos_justify_req && space_ok;
  assign do_neg   = frame_start && !pointer_load && !pos_justify_req &&
                    neg_justify_req && space_ok;

  // Request bits: a write of one arms, insertion clears; a write that
  // lands with the insertion still wins so the new request is kept
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_ctrl_q <= RST_PTR_CTRL;
    end else begin
      if (do_load) begin
        ptr_ctrl_q[PC_LOAD_BIT] <= 1'b0;
      end
      if (do_pos) begin
        ptr_ctrl_q[PC_POS_BIT] <= 1'b0;
      end
      if (do_neg) begin
        ptr_ctrl_q[PC_NEG_BIT] <= 1'b0;
      end
      if (wr_acc && hit(paddr, IDX_PTR_CTRL)) begin
        ptr_ctrl_q[PC_GAP_BIT]  <= wr_byte[PC_GAP_BIT];
        ptr_ctrl_q[PC_FLAG_BIT] <= wr_byte[PC_FLAG_BIT];
        // Only a zero-to-one change arms a request; a bit being cleared
        // now counts as zero, so a request written then is not lost
        if (!wr_byte[PC_POS_BIT] || !pos_justify_req || do_pos) begin
          ptr_ctrl_q[PC_POS_BIT] <= wr_byte[PC_POS_BIT];
        end
        if (!wr_byte[PC_NEG_BIT] || !neg_justify_req || do_neg) begin
          ptr_ctrl_q[PC_NEG_BIT] <= wr_byte[PC_NEG_BIT];
        end
        if (!wr_byte[PC_LOAD_BIT] || !pointer_load || do_load) begin
          ptr_ctrl_q[PC_LOAD_BIT] <= wr_byte[PC_LOAD_BIT];
        end
      end
    end
  end

  // Frames since the last inserted justification, saturating
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gap_cnt_q <= STUFF_GAP;
    end else if (do_pos || do_neg) begin
      gap_cnt_q <= 2'h0;
    end else if (frame_start && gap_cnt_q != STUFF_GAP) begin
      gap_cnt_q <= gap_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_ptr_q     <= 10'h000;
      timing_ptr_q <= 10'h000;
    end else if (do_load) begin
      tx_ptr_q <= arb_ptr;
      // Envelope timing only follows a valid pointer
      if (arb_ptr <= PTR_MAX) begin
        timing_ptr_q <= arb_ptr;
      end
    end else if (do_pos || do_neg) begin
      tx_ptr_q     <= ptr_step(timing_ptr_q, do_pos);
      timing_ptr_q <= ptr_step(timing_ptr_q, do_pos);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q       <= '0;
      ptr_valid_q <= 1'b0;
    end else begin
      ptr_valid_q <= frame_start;
      if (frame_start) begin
        ptr_q.pos_stuff <= do_pos;
        ptr_q.neg_stuff <= do_neg;
        if (do_load) begin
          ptr_q.word       <= {new_flag_pattern, spare_bits, arb_ptr};
          ptr_q.timing_ptr <= (arb_ptr <= PTR_MAX) ? arb_ptr
                                                  : timing_ptr_q;
        end else if (do_pos) begin
          ptr_q.word       <= {flag_sel, spare_bits,
                               timing_ptr_q ^ PTR_INC_MASK};
          ptr_q.timing_ptr <= timing_ptr_q;
        end else if (do_neg) begin
          ptr_q.word       <= {flag_sel, spare_bits,
                               timing_ptr_q ^ PTR_DEC_MASK};
          ptr_q.timing_ptr <= timing_ptr_q;
        end else begin
          // Later frames go back to the normal or continuous pattern
          ptr_q.word       <= {flag_sel, spare_bits, tx_ptr_q};
          ptr_q.timing_ptr <= timing_ptr_q;
        end
      end
    end
  end

  assign ptr_out       = ptr_q;
  assign ptr_out_valid = ptr_valid_q;

  // Remote error pulses counted per frame; previous frame's count is kept
  logic [3:0] err_acc_q;
  logic [3:0] err_prev_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      err_acc_q  <= 4'h0;
      err_prev_q <= 4'h0;
    end else if (frame_start) begin
      err_prev_q <= err_acc_q;
      err_acc_q  <= {3'h0, remote_error_pulse_in};
    end else if (remote_error_pulse_in && err_acc_q != ERR_CNT_MAX) begin
      err_acc_q <= err_acc_q + 4'h1;
    end
  end

  // Path overhead byte assembly
  logic [3:0] remote_error_override;
  logic [3:0] err_field;
  logic [7:0] int_byte;
  logic       src_sel_bit;
  logic       take_ext;
  logic       int_bit;
  logic [7:0] asm_q;
  logic       err_int_q;
  txpo_poh_t  poh_q;
  logic       poh_valid_q;
  logic       g1_done;

  assign remote_error_override = status_q[PS_ERR_LSB +: 4];
  // A pending override replaces the accumulated count
  assign err_field = (remote_error_override != 4'h0)
                     ? remote_error_override : err_prev_q;

  always_comb begin
    int_byte    = 8'h00;
    src_sel_bit = 1'b0;
    case (poh_slot)
      SLOT_J1: begin
        int_byte    = DEF_TRACE;
        src_sel_bit = src_sel_q[0];
      end
      SLOT_F2: begin
        int_byte    = DEF_USER;
        src_sel_bit = src_sel_q[1];
      end
      SLOT_G1: begin
        int_byte    = {err_field,
                       status_q[PS_YEL_BIT] | path_yellow_in,
                       status_q[PS_SPARE_LSB +: 3]};
        src_sel_bit = src_sel_q[2];
      end
      SLOT_C2: begin
        int_byte    = label_q;
        src_sel_bit = src_sel_q[3];
      end
      SLOT_Z3: begin
        int_byte    = DEF_GROWTH;
        src_sel_bit = src_sel_q[4];
      end
      SLOT_Z4: begin
        int_byte    = DEF_GROWTH;
        src_sel_bit = src_sel_q[5];
      end
      SLOT_Z5: begin
        int_byte    = DEF_GROWTH;
        src_sel_bit = src_sel_q[6];
      end
      default: begin
        int_byte    = 8'h00;
        src_sel_bit = 1'b0;
      end
    endcase
  end

  // Per bit, so the enable may pick single G1 fields from the input
  assign take_ext = src_sel_bit | ext_overhead_enable;
  assign int_bit  = int_byte[3'h7 - poh_bit_idx];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      asm_q     <= 8'h00;
      err_int_q <= 1'b0;
    end else if (poh_bit_strobe && poh_slot != SLOT_NONE) begin
      // Serial data is taken in this byte's own slot, MSB first
      asm_q <= {asm_q[6:0], take_ext ? ext_overhead_serial_in
                                     : int_bit};
      if (poh_bit_idx == 3'h0) begin
        err_int_q <= !take_ext;
      end else if (poh_bit_idx <= 3'h3) begin
        err_int_q <= err_int_q & !take_ext;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      poh_q       <= '{slot: SLOT_NONE, data: 8'h00};
      poh_valid_q <= 1'b0;
    end else begin
      poh_valid_q <= poh_bit_strobe && poh_slot != SLOT_NONE &&
                     poh_bit_idx == 3'h7;
      if (poh_bit_strobe && poh_slot != SLOT_NONE && poh_bit_idx == 3'h7)
      begin
        poh_q.slot <= poh_slot;
        poh_q.data <= {asm_q[6:0], take_ext ? ext_overhead_serial_in
                                            : int_bit};
      end
    end
  end

  assign poh_out       = poh_q;
  assign poh_out_valid = poh_valid_q;

  // Override clears once its bits went out internally
  assign g1_done = poh_bit_strobe && poh_slot == SLOT_G1 &&
                   poh_bit_idx == 3'h7 && err_int_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= RST_PATH_STATUS;
    end else if (wr_acc && hit(paddr, IDX_PATH_STATUS)) begin
      status_q <= wr_byte; // write wins over the automatic clear
    end else if (g1_done) begin
      status_q[PS_ERR_LSB +: 4] <= 4'h0;
    end
  end

endmodule

// ==== txpo_asserts.sv ====
// Port-level checker of the path overhead block
`timescale 1ns/100ps
module txpo_asserts (
  input wire logic                        mclk,
  input wire logic                        reset_n,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic [txpo_pkg::APB_AW-1:0] paddr,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        frame_start,
  input wire txpo_pkg::txpo_slot_t        poh_slot,
  input wire logic                        poh_bit_strobe,
  input wire logic [2:0]                  poh_bit_idx,
  input wire txpo_pkg::txpo_poh_t         poh_out,
  input wire logic                        poh_out_valid,
  input wire txpo_pkg::txpo_ptr_t         ptr_out,
  input wire logic                        ptr_out_valid
);
  import txpo_pkg::*;
  logic [9:0] ix;
  logic       mapped;
  assign ix = paddr[11:2];
  assign mapped = paddr[1:0] == 2'h0 && ix[9:8] == 2'h0 &&
                  ix[7:0] inside {IDX_PTR_CTRL, IDX_SRC_SEL, IDX_ARB_LOW,
                                  IDX_ARB_HIGH, IDX_LABEL, IDX_PATH_STATUS};
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  ready_high_a: assert property (pready)
    else $error("pready dropped");
  err_decode_a: assert property (pslverr == (psel && penable && !mapped))
    else $error("pslverr does not match the address decode");
  ptr_valid_a: assert property (frame_start |=> ptr_out_valid)
    else $error("no pointer after frame start");
  ptr_cause_a: assert property (ptr_out_valid |-> $past(frame_start))
    else $error("pointer without frame start");
  ptr_hold_a: assert property (!ptr_out_valid |-> $stable(ptr_out))
    else $error("pointer changed between frames");
  poh_valid_a: assert property (poh_bit_strobe && poh_bit_idx == 3'h7 &&
    poh_slot != SLOT_NONE |=> poh_out_valid)
    else $error("no byte after last bit");
  poh_cause_a: assert property (poh_out_valid |->
    $past(poh_bit_strobe) && $past(poh_bit_idx) == 3'h7)
    else $error("byte without last bit");
  poh_hold_a: assert property (!poh_out_valid |-> $stable(poh_out))
    else $error("byte output changed between bytes");
  slot_match_a: assert property (poh_out_valid |->
    poh_out.slot == $past(poh_slot))
    else $error("byte tagged with wrong slot");
  stuff_excl_a: assert property (ptr_out_valid |->
    !(ptr_out.pos_stuff && ptr_out.neg_stuff))
    else $error("both stuff directions in one frame");
endmodule
bind txpo_tx_path_overhead_proc txpo_asserts u_chk (.mclk, .reset_n, .psel,
  .penable, .paddr, .pready, .pslverr, .frame_start, .poh_slot,
  .poh_bit_strobe, .poh_bit_idx, .poh_out, .poh_out_valid, .ptr_out,
  .ptr_out_valid);

// ==== txpo_line_model.sv ====
// Far-side model: frame timing source and frame stream sink
`timescale 1ns/100ps
module txpo_line_model (
  input  wire logic                 mclk,
  output logic                      frame_start,
  output txpo_pkg::txpo_slot_t      poh_slot,
  output logic                      poh_bit_strobe,
  output logic [2:0]                poh_bit_idx,
  output logic                      ext_overhead_enable,
  output logic                      ext_overhead_serial_in,
  input  wire txpo_pkg::txpo_poh_t  poh_out,
  input  wire logic                 poh_out_valid,
  input  wire txpo_pkg::txpo_ptr_t  ptr_out,
  input  wire logic                 ptr_out_valid
);
  import txpo_pkg::*;
  txpo_poh_t poh_q;
  txpo_ptr_t ptr_q;
  initial begin
    frame_start = 1'b0;
    poh_slot = SLOT_NONE;
    poh_bit_strobe = 1'b0;
    poh_bit_idx = 3'h0;
    ext_overhead_enable = 1'b0;
    ext_overhead_serial_in = 1'b0;
  end
  always @(posedge mclk) begin
    if (poh_out_valid) poh_q <= poh_out;
    if (ptr_out_valid) ptr_q <= ptr_out;
  end
  task automatic frame();
    @(posedge mclk);
    frame_start <= 1'b1;
    @(posedge mclk);
    frame_start <= 1'b0;
  endtask
  // Between strobes the lines carry the inverse, so stale bits show up
  task automatic send_byte(input txpo_slot_t s, input logic [7:0] en,
                           input logic [7:0] d);
    int k;
    for (k = 0; k < 8; k++) begin
      @(posedge mclk);
      poh_slot <= s;
      poh_bit_strobe <= 1'b1;
      poh_bit_idx <= 3'(k);
      ext_overhead_enable <= en[7-k];
      ext_overhead_serial_in <= d[7-k];
      @(posedge mclk);
      poh_bit_strobe <= 1'b0;
      ext_overhead_enable <= ~en[7-k];
      ext_overhead_serial_in <= ~d[7-k];
    end
    poh_slot <= SLOT_NONE;
  endtask
endmodule

// ==== txpo_tx_path_overhead_proc_tb.sv ====
// Self-checking bench for the path overhead block
`timescale 1ns/100ps
module txpo_tx_path_overhead_proc_tb;
  import txpo_pkg::*;
  logic              mclk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic              frame_start, poh_bit_strobe, poh_out_valid;
  logic              ext_overhead_enable, ext_overhead_serial_in;
  logic              remote_error_pulse_in, path_yellow_in, ptr_out_valid;
  logic [2:0]        poh_bit_idx;
  txpo_slot_t        poh_slot;
  txpo_poh_t         poh_out;
  txpo_ptr_t         ptr_out;
  int                failures = 0, cmp_count = 0, cycles = 0, seed, i, k;
  logic [7:0]        rd, src, lab, ps, en, dat, ix, m;
  logic [9:0]        ptr_e;
  logic              yel, slv_err;
  logic [7:0]        idx_tab [6] = '{IDX_PTR_CTRL, IDX_SRC_SEL, IDX_ARB_LOW,
                                     IDX_ARB_HIGH, IDX_LABEL, IDX_PATH_STATUS};
  logic [7:0]        rst_tab [6] = '{8'h00, 8'h00, 8'h00, 8'h90, 8'h13, 8'h00};

  txpo_tx_path_overhead_proc #(.DEF_TRACE(8'h5a), .DEF_USER(8'h3c),
    .DEF_GROWTH(8'ha5)) u_dut (.mclk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .frame_start, .poh_slot,
    .poh_bit_strobe, .poh_bit_idx, .ext_overhead_enable,
    .ext_overhead_serial_in, .remote_error_pulse_in, .path_yellow_in,
    .poh_out, .poh_out_valid, .ptr_out, .ptr_out_valid);
  txpo_line_model u_far (.mclk, .frame_start, .poh_slot, .poh_bit_strobe,
    .poh_bit_idx, .ext_overhead_enable, .ext_overhead_serial_in, .poh_out,
    .poh_out_valid, .ptr_out, .ptr_out_valid);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      failures = failures + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits on pready; only the bench timeout ends a stuck access
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h00_0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(32'(rd), 32'(e));
  endtask
  function automatic logic [7:0] defv(input logic [2:0] s);
    case (s)
      3'h0: return 8'h5a;
      3'h1: return 8'h3c;
      3'h2: return {4'h0, ps[3] | yel, ps[2:0]};
      3'h3: return lab;
      default: return 8'ha5;
    endcase
  endfunction
  task automatic byte_chk(input txpo_slot_t s, input logic [7:0] e);
    u_far.send_byte(s, en, dat);
    repeat (2) @(posedge mclk);
    chk(32'(u_far.poh_q), 32'({s, e}));
  endtask
  task automatic fchk(input logic [15:0] w, input logic p, input logic n);
    u_far.frame();
    repeat (2) @(posedge mclk);
    chk(32'({u_far.ptr_q.word, u_far.ptr_q.pos_stuff,
             u_far.ptr_q.neg_stuff}), 32'({w, p, n}));
  endtask
  task automatic pulse();
    @(posedge mclk);
    remote_error_pulse_in <= 1'b1;
    @(posedge mclk);
    remote_error_pulse_in <= 1'b0;
  endtask

  initial begin
    seed = 19035;
    {psel, penable, pwrite, remote_error_pulse_in, path_yellow_in} = 5'h0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    reset_n = 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    for (i = 0; i < 6; i++) rchk(idx_tab[i], rst_tab[i]);
    rchk(8'h43, 8'h00);
    chk(32'(slv_err), 32'h0000_0001);
    $display("register reset test done");
    u_far.frame();
    lab = 8'($random(seed));
    apb(1'b1, IDX_LABEL, lab);
    for (i = 0; i < 42; i++) begin
      src = 8'($random(seed)) & 8'h7f;
      ps = {4'h0, 4'($random(seed))};
      yel = 1'($random(seed));
      en = (i < 14) ? 8'h00 : 8'($random(seed));
      dat = 8'($random(seed));
      ix = 8'(i % 7);
      apb(1'b1, IDX_SRC_SEL, src);
      apb(1'b1, IDX_PATH_STATUS, ps);
      path_yellow_in <= yel;
      m = en | {8{src[ix[2:0]]}};
      byte_chk(txpo_slot_t'(ix[2:0]), (dat & m) |
        (defv(ix[2:0]) & ~m));
    end
    $display("overhead byte source test done");
    en = 8'h00;
    yel = 1'b0;
    path_yellow_in <= 1'b0;
    apb(1'b1, IDX_SRC_SEL, 8'h00);
    apb(1'b1, IDX_PATH_STATUS, 8'h5a);
    rchk(IDX_PATH_STATUS, 8'h5a);
    byte_chk(SLOT_G1, 8'h5a);
    rchk(IDX_PATH_STATUS, 8'h0a);
    repeat (3) pulse();
    u_far.frame();
    byte_chk(SLOT_G1, 8'h3a);
    pulse();
    u_far.frame();
    apb(1'b1, IDX_PATH_STATUS, 8'h7a);
    byte_chk(SLOT_G1, 8'h7a);
    $display("path status test done");
    apb(1'b1, IDX_ARB_LOW, 8'h34);
    apb(1'b1, IDX_ARB_HIGH, 8'ha9);
    apb(1'b1, IDX_PTR_CTRL, 8'h10);
    ptr_e = 10'h134;
    fchk({4'ha, 2'h2, ptr_e}, 1'b0, 1'b0);
    rchk(IDX_PTR_CTRL, 8'h00);
    fchk({FLAG_NORMAL, 2'h2, ptr_e}, 1'b0, 1'b0);
    apb(1'b1, IDX_PTR_CTRL, 8'h08);
    fchk({4'ha, 2'h2, ptr_e}, 1'b0, 1'b0);
    apb(1'b1, IDX_PTR_CTRL, 8'h02);
    fchk({FLAG_NORMAL, 2'h2, ptr_e ^ PTR_INC_MASK}, 1'b1, 1'b0);
    rchk(IDX_PTR_CTRL, 8'h00);
    ptr_e = ptr_e + 10'h001;
    apb(1'b1, IDX_PTR_CTRL, 8'h24);
    for (k = 1; k < 5; k++)
      fchk({FLAG_NORMAL, 2'h2, (k == 4) ? ptr_e ^ PTR_DEC_MASK : ptr_e},
           1'b0, k == 4);
    ptr_e = ptr_e - 10'h001;
    apb(1'b1, IDX_PTR_CTRL, 8'h02);
    fchk({FLAG_NORMAL, 2'h2, ptr_e ^ PTR_INC_MASK}, 1'b1, 1'b0);
    ptr_e = ptr_e + 10'h001;
    apb(1'b1, IDX_ARB_LOW, 8'h10);
    apb(1'b1, IDX_ARB_HIGH, 8'h93);
    apb(1'b1, IDX_PTR_CTRL, 8'h10);
    fchk({4'h9, 2'h0, 10'h310}, 1'b0, 1'b0);
    chk(32'(u_far.ptr_q.timing_ptr), 32'(ptr_e));
    $display("pointer test done");
    end_of_test();
  end
endmodule
